/* mcadc_capture.sv */
// Four-channel capture sequencer: sample clock divider, trigger unit,
// sample word packer and bus-master writer into a circular host buffer.
// Assumes all inputs synchronous to sys_clk and a master that accepts
// one write when mst_ready is high.
// Operation
// - Count zero enables no channel; count one enables channel zero only.
// - Count two enables channels zero and one, stored alternately, zero first.
// - Count four enables all channels, stored in order zero to three.
// - Started capture runs until the programmed count completes, the trigger in pre mode, the post count after trigger in middle mode, or stop.
// - Each sample is one 16-bit word, 12-bit result in top bits.
// - Ten-bit variant fills only the upper ten bits of the word.
// - Lowest three bits carry the three digital inputs, sampled with conversion.
// - Bit three is the trigger flag, one once a trigger was seen.
// - Status codes: 0 done, 1 transferring, 2 wait trigger, 3 wait delay.
// - Report index of the oldest valid sample; reading wraps to zero.
// - On stop, report samples transferred, for stop or terminal count.
// - Clock source 0 internal, 1 external sine, 2 external square.
// - Divisor must be even from 2 to 1024; others are invalid.
// - Five modes: software, post, pre, delayed and middle trigger.
// - Trigger source is analog channel zero to three or external input.
// - Slope 0 fires on rising crossing, slope 1 on falling crossing.
// - Analog trigger compares the selected channel with an 8-bit level.
// - Writing the post count register preloads the down-counter.
// - After trigger the counter decrements each sample edge, halts at 0.
// - Counter sets delay in delayed mode, samples after trigger in middle.
`timescale 1ns/1ps
`default_nettype none
module mcadc_capture
  import mcadc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [11:0] adc_ch0_data,
  input wire logic [11:0] adc_ch1_data,
  input wire logic [11:0] adc_ch2_data,
  input wire logic [11:0] adc_ch3_data,
  input wire logic digital_in_0,
  input wire logic digital_in_1,
  input wire logic digital_in_2,
  input wire logic ext_trig,
  input wire logic ext_sine_clk,
  input wire logic ext_square_clk,
  output logic [3:0] adc_ch_enable,
  output logic adc_convert,
  output logic [31:0] mst_addr,
  output logic [31:0] mst_wdata,
  output logic mst_valid,
  input wire logic mst_ready
);

  typedef struct packed {
    mcadc_state_t fsm;
    logic [2:0] enabled_channel_count;
    logic res10;
    logic [1:0] clk_src;
    logic sample_clock_faster_than_bus;
    logic [10:0] div;
    logic div_err;
    logic [2:0] trig_mode;
    logic [2:0] trig_src;
    logic slope;
    logic [7:0] level;
    logic [15:0] post_cnt;
    logic [23:0] conv_n;
    logic [31:0] buf_base;
    logic [23:0] buf_size;
    logic [10:0] div_cnt;
    logic ext_prev;
    logic lvl_above;
    logic lvl_valid;
    logic trig_seen;
    logic [3:0][15:0] words;
    logic [2:0] emit_idx;
    logic [2:0] emit_left;
    logic [15:0] half;
    logic half_v;
    logic [31:0] half_addr;
    logic [23:0] wr_idx;
    logic [23:0] xfer_cnt;
    logic wrapped;
    logic stop_req;
    logic [31:0] m_addr;
    logic [31:0] m_data;
    logic m_valid;
    logic overrun;
    logic [31:0] rdata;
  } mcadc_regs_t;

  mcadc_regs_t r;
  mcadc_regs_t n;

  logic [3:0][11:0] ch_data;
  logic src_edge;
  logic ext_lvl;
  logic tick;
  logic [11:0] trig_data;
  logic cur_above;
  logic armed;
  logic trig_hit;
  logic bus_free;
  logic count_mode;
  logic [15:0] word;
  logic [23:0] idx_inc;
  logic [2:0] new_count;
  logic [10:0] new_div;

  assign ch_data = {adc_ch3_data, adc_ch2_data, adc_ch1_data, adc_ch0_data};

  function automatic logic [3:0] chan_mask(input logic [2:0] cnt);
    case (cnt)
      3'h1: chan_mask = 4'h1;
      3'h2: chan_mask = 4'h3;
      3'h4: chan_mask = 4'hF;
      default: chan_mask = 4'h0;
    endcase
  endfunction

  function automatic logic [1:0] xfer_status(input mcadc_state_t st);
    case (st)
      MCADC_S_WAIT_TRIG: xfer_status = MCADC_XFER_WAIT_TRIG;
      MCADC_S_DELAY: xfer_status = MCADC_XFER_WAIT_DELAY;
      MCADC_S_RUN, MCADC_S_FLUSH: xfer_status = MCADC_XFER_ACTIVE;
      default: xfer_status = MCADC_XFER_DONE;
    endcase
  endfunction

  // Ten-bit parts leave result bits 1:0 undefined, so they are forced low
  function automatic logic [15:0] make_word(input logic [11:0] d, input logic res10,
                                            input logic flag, input logic [2:0] di);
    make_word = {d[11:2], (res10 ? 2'h0 : d[1:0]), flag, di};
  endfunction

  always_comb
  begin
    n = r;
    n.rdata = 32'h0000_0000;
    n.m_valid = r.m_valid && !mst_ready;
    bus_free = !r.m_valid || mst_ready;
    count_mode = (r.trig_mode != MCADC_MODE_PRE) && (r.trig_mode != MCADC_MODE_MIDDLE);
    new_count = reg_wdata[MCADC_CTRL_CHCNT_LSB +: 3];
    new_div = reg_wdata[MCADC_CLK_DIV_LSB +: 11];
    idx_inc = 24'(r.wr_idx + 24'h000001);
    word = r.words[r.emit_idx[1:0]];

    // Sample clock source and divider
    case (r.clk_src)
      MCADC_CLOCK_SOURCE_INTERNAL: ext_lvl = 1'b0;
      MCADC_CLOCK_SOURCE_EXT_SINE: ext_lvl = ext_sine_clk;
      MCADC_CLOCK_SOURCE_EXT_SQUARE: ext_lvl = ext_square_clk;
      default: ext_lvl = 1'b0;
    endcase
    src_edge = (r.clk_src == MCADC_CLOCK_SOURCE_INTERNAL) || (ext_lvl && !r.ext_prev);
    n.ext_prev = ext_lvl;
    tick = 1'b0;
    if (r.fsm == MCADC_S_IDLE)
      n.div_cnt = 11'h000;
    else if (src_edge)
    begin
      if (r.div_cnt == 11'(r.div - 11'h001))
      begin
        tick = 1'b1;
        n.div_cnt = 11'h000;
      end
      else
        n.div_cnt = 11'(r.div_cnt + 11'h001);
    end

    // Trigger detection, evaluated once per sample edge
    case (r.trig_src)
      MCADC_EVENT_SOURCE_CHANNEL0: trig_data = adc_ch0_data;
      MCADC_EVENT_SOURCE_CHANNEL1: trig_data = adc_ch1_data;
      MCADC_EVENT_SOURCE_CHANNEL2: trig_data = adc_ch2_data;
      MCADC_EVENT_SOURCE_CHANNEL3: trig_data = adc_ch3_data;
      default: trig_data = 12'h000;
    endcase
    if (r.trig_src == MCADC_EVENT_SOURCE_EXTERNAL)
      cur_above = ext_trig;
    else
      cur_above = $signed(trig_data[11:4]) >= $signed(r.level);
    armed = (r.fsm == MCADC_S_WAIT_TRIG) || ((r.fsm == MCADC_S_RUN) && !count_mode);
    trig_hit = tick && armed && !r.trig_seen && r.lvl_valid &&
               (r.slope ? (r.lvl_above && !cur_above) : (!r.lvl_above && cur_above));
    if (tick)
    begin
      n.lvl_above = cur_above;
      n.lvl_valid = 1'b1;
    end
    if (trig_hit)
      n.trig_seen = 1'b1;
    if (tick && r.trig_seen && (r.post_cnt != 16'h0000))
      n.post_cnt = 16'(r.post_cnt - 16'h0001);

    // Packer: first sample of a pair waits in the low half
    if ((r.emit_left != 3'h0) && bus_free)
    begin
      if (r.half_v)
      begin
        n.m_addr = r.half_addr;
        n.m_data = {word, r.half};
        n.m_valid = 1'b1;
        n.half_v = 1'b0;
      end
      else
      begin
        n.half = word;
        n.half_addr = r.buf_base + {7'h00, r.wr_idx, 1'b0};
        n.half_v = 1'b1;
      end
      if (idx_inc == r.buf_size)
      begin
        n.wr_idx = 24'h000000;
        n.wrapped = 1'b1;
      end
      else
        n.wr_idx = idx_inc;
      n.xfer_cnt = 24'(r.xfer_cnt + 24'h000001);
      n.emit_idx = 3'(r.emit_idx + 3'h1);
      n.emit_left = 3'(r.emit_left - 3'h1);
      if (count_mode && (24'(r.xfer_cnt + 24'h000001) == r.conv_n))
      begin
        n.emit_left = 3'h0;
        n.stop_req = 1'b1;
      end
    end

    case (r.fsm)
      MCADC_S_WAIT_TRIG:
        if (trig_hit)
        begin
          if (r.trig_mode == MCADC_DELAYED_EVENT_MODE)
            n.fsm = MCADC_S_DELAY;
          else
            n.fsm = MCADC_S_RUN;
        end
      MCADC_S_DELAY:
        if (r.post_cnt == 16'h0000)
          n.fsm = MCADC_S_RUN;
      MCADC_S_RUN:
      begin
        if (tick)
        begin
          // A new set while the last is still draining is dropped, not merged
          if (r.emit_left != 3'h0)
            n.overrun = 1'b1;
          else if (!r.stop_req)
          begin
            for (int i = 0; i < 4; i++)
              n.words[i] = make_word(ch_data[i], r.res10, r.trig_seen | trig_hit,
                                     {digital_in_2, digital_in_1, digital_in_0});
            n.emit_left = r.enabled_channel_count;
            n.emit_idx = 3'h0;
          end
        end
        if ((r.trig_mode == MCADC_MODE_PRE) && trig_hit)
          n.stop_req = 1'b1;
        if ((r.trig_mode == MCADC_MODE_MIDDLE) && r.trig_seen && (r.post_cnt == 16'h0000))
          n.stop_req = 1'b1;
        if (r.stop_req && (r.emit_left == 3'h0))
          n.fsm = MCADC_S_FLUSH;
      end
      MCADC_S_FLUSH:
        if (bus_free)
        begin
          if (r.half_v)
          begin
            n.m_addr = r.half_addr;
            n.m_data = {16'h0000, r.half};
            n.m_valid = 1'b1;
            n.half_v = 1'b0;
          end
          else
            n.fsm = MCADC_S_IDLE;
        end
      default:
        n.fsm = MCADC_S_IDLE;
    endcase

    // Register writes; configuration except the post count is locked while a capture is active
    if (reg_wr)
    begin
      case (reg_addr)
        MCADC_REG_CTRL:
          if (r.fsm == MCADC_S_IDLE)
          begin
            n.res10 = reg_wdata[MCADC_CTRL_RES10_BIT];
            n.enabled_channel_count = new_count;
            if (reg_wdata[MCADC_CTRL_START_BIT] && (chan_mask(new_count) != 4'h0) &&
                !(count_mode && (r.conv_n == 24'h000000)))
            begin
              n.wr_idx = 24'h000000;
              n.xfer_cnt = 24'h000000;
              n.wrapped = 1'b0;
              n.trig_seen = 1'b0;
              n.lvl_valid = 1'b0;
              n.half_v = 1'b0;
              n.stop_req = 1'b0;
              n.overrun = 1'b0;
              n.emit_left = 3'h0;
              if ((r.trig_mode == MCADC_MODE_POST) || (r.trig_mode == MCADC_DELAYED_EVENT_MODE))
                n.fsm = MCADC_S_WAIT_TRIG;
              else
                n.fsm = MCADC_S_RUN;
            end
          end
          else if (reg_wdata[MCADC_CTRL_STOP_BIT])
          begin
            if ((r.fsm == MCADC_S_WAIT_TRIG) || (r.fsm == MCADC_S_DELAY))
              n.fsm = MCADC_S_IDLE;
            else
            begin
              n.stop_req = 1'b1;
              n.emit_left = 3'h0;
            end
          end
        MCADC_REG_CLK:
          if (r.fsm == MCADC_S_IDLE)
          begin
            n.clk_src = reg_wdata[MCADC_CLK_SRC_LSB +: 2];
            n.sample_clock_faster_than_bus = reg_wdata[MCADC_CLK_FASTER_BIT];
            if (!new_div[0] && (new_div >= MCADC_DIV_MIN) && (new_div <= MCADC_DIV_MAX))
            begin
              n.div = new_div;
              n.div_err = 1'b0;
            end
            else
              n.div_err = 1'b1;
          end
        MCADC_REG_TRIG:
          if (r.fsm == MCADC_S_IDLE)
          begin
            n.trig_mode = reg_wdata[MCADC_TRIG_MODE_LSB +: 3];
            n.trig_src = reg_wdata[MCADC_TRIG_SRC_LSB +: 3];
            n.slope = reg_wdata[MCADC_TRIG_SLOPE_BIT];
            n.level = reg_wdata[MCADC_TRIG_LEVEL_LSB +: 8];
          end
        MCADC_REG_POST:
          n.post_cnt = reg_wdata[15:0];
        MCADC_REG_COUNT:
          if (r.fsm == MCADC_S_IDLE)
            n.conv_n = reg_wdata[23:0];
        MCADC_REG_BASE:
          if (r.fsm == MCADC_S_IDLE)
            n.buf_base = {reg_wdata[31:2], 2'h0};
        MCADC_REG_SIZE:
          if (r.fsm == MCADC_S_IDLE)
            n.buf_size = {reg_wdata[23:1], 1'b0};
        default:
          n.buf_size = n.buf_size;
      endcase
    end

    if (reg_rd)
    begin
      case (reg_addr)
        MCADC_REG_CTRL: n.rdata = {25'h0, r.enabled_channel_count, 1'b0, r.res10, 2'h0};
        MCADC_REG_CLK: n.rdata = {5'h00, r.div, 13'h0000, r.sample_clock_faster_than_bus,
                                  r.clk_src};
        MCADC_REG_TRIG: n.rdata = {8'h00, r.level, 7'h00, r.slope, 1'b0, r.trig_src, 1'b0,
                                   r.trig_mode};
        MCADC_REG_POST: n.rdata = {16'h0000, r.post_cnt};
        MCADC_REG_COUNT: n.rdata = {8'h00, r.conv_n};
        MCADC_REG_BASE: n.rdata = r.buf_base;
        MCADC_REG_SIZE: n.rdata = {8'h00, r.buf_size};
        MCADC_REG_STATUS: n.rdata = {28'h0000000, r.overrun, r.div_err, xfer_status(r.fsm)};
        MCADC_REG_XFER: n.rdata = {8'h00, r.xfer_cnt};
        MCADC_REG_START_IDX: n.rdata = {8'h00, (r.wrapped ? r.wr_idx : 24'h000000)};
        default: n.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      r <= '0;
      r.div <= MCADC_DIV_RST;
    end
    else
      r <= n;
  end

  assign adc_ch_enable = (r.fsm != MCADC_S_IDLE) ? chan_mask(r.enabled_channel_count) : 4'h0;
  assign adc_convert = tick;
  assign reg_rdata = r.rdata;
  assign mst_addr = r.m_addr;
  assign mst_wdata = r.m_data;
  assign mst_valid = r.m_valid;

  single_enable_a: assert property (@(posedge sys_clk) disable iff (rst)
    (r.fsm != MCADC_S_IDLE) && (r.enabled_channel_count == 3'h1) |-> adc_ch_enable == 4'h1)
    else $error("single channel enable wrong");
  pair_enable_a: assert property (@(posedge sys_clk) disable iff (rst)
    (r.fsm != MCADC_S_IDLE) && (r.enabled_channel_count == 3'h2) |-> adc_ch_enable == 4'h3)
    else $error("pair channel enable wrong");
  quad_capture_a: assert property (@(posedge sys_clk) disable iff (rst)
    (r.fsm == MCADC_S_RUN) && tick && (r.emit_left == 3'h0) && !r.stop_req &&
    !(reg_wr && (reg_addr == MCADC_REG_CTRL)) &&
    (r.enabled_channel_count == 3'h4) |=> (r.emit_left == 3'h4) && (adc_ch_enable == 4'hF))
    else $error("four channel set not queued");
  run_keeps_a: assert property (@(posedge sys_clk) disable iff (rst)
    (r.fsm == MCADC_S_RUN) |=> (r.fsm != MCADC_S_IDLE))
    else $error("capture ended without flush");
  word_layout_a: assert property (@(posedge sys_clk) disable iff (rst)
    (r.fsm == MCADC_S_RUN) && tick && (r.emit_left == 3'h0) && !r.stop_req && !r.res10
    |=> (r.words[1][15:4] == $past(adc_ch1_data)) &&
        (r.words[1][2:0] == $past({digital_in_2, digital_in_1, digital_in_0})))
    else $error("sample word layout wrong");
  res10_low_a: assert property (@(posedge sys_clk) disable iff (rst)
    (r.fsm == MCADC_S_RUN) && tick && (r.emit_left == 3'h0) && !r.stop_req && r.res10
    |=> (r.words[0][5:4] == 2'h0) && (r.words[0][15:6] == $past(adc_ch0_data[11:2])))
    else $error("ten bit word not masked");
  flag_bit_a: assert property (@(posedge sys_clk) disable iff (rst)
    (r.fsm == MCADC_S_RUN) && tick && (r.emit_left == 3'h0) && !r.stop_req
    |=> r.words[0][3] == r.trig_seen)
    else $error("trigger flag mismatch");
  delay_status_a: assert property (@(posedge sys_clk) disable iff (rst)
    reg_rd && (reg_addr == MCADC_REG_STATUS) && (r.fsm == MCADC_S_DELAY)
    |=> reg_rdata[1:0] == MCADC_XFER_WAIT_DELAY)
    else $error("delay status code wrong");
  div_reject_a: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr && (reg_addr == MCADC_REG_CLK) && (r.fsm == MCADC_S_IDLE) && new_div[0]
    |=> r.div_err && (r.div == $past(r.div)))
    else $error("odd divisor accepted");
  post_preload_a: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr && (reg_addr == MCADC_REG_POST) |=> r.post_cnt == $past(reg_wdata[15:0]))
    else $error("post count not preloaded");
  post_halt_a: assert property (@(posedge sys_clk) disable iff (rst)
    (r.post_cnt == 16'h0000) && !(reg_wr && (reg_addr == MCADC_REG_POST)) |=> r.post_cnt == 16'h0000)
    else $error("post counter moved past zero");
  bus_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    mst_valid && !mst_ready |=> mst_valid && $stable(mst_addr) && $stable(mst_wdata))
    else $error("bus write dropped while stalled");

endmodule
`default_nettype wire

/* mcadc_host_mem.sv */
// Host memory model behind the capture block's bus-master write port.
// Assumes word-aligned writes into a 64-word window, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module mcadc_host_mem
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic [31:0] mst_addr,
  input wire logic [31:0] mst_wdata,
  input wire logic mst_valid,
  output logic mst_ready
);
  logic [31:0] mem [0:63];
  logic ph_r;
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ph_r <= 1'b0;
      for (int i = 0; i < 64; i++)
        mem[i] <= 32'hA5A5A5A5;
    end
    else
    begin
      ph_r <= ~ph_r;
      if (mst_valid && mst_ready)
        mem[mst_addr[7:2]] <= mst_wdata;
    end
  end
  // Slow host takes every other cycle, so the device must hold its write
  assign mst_ready = slow ? ph_r : 1'b1;
endmodule
`default_nettype wire

/* mcadc_pkg.sv */
// Constants shared by the capture sequencer: register map, fields, encodings.
// Assumes a 32-bit register port and byte addresses on an 8-bit offset.
`default_nettype none
package mcadc_pkg;
  localparam logic [7:0] MCADC_REG_CTRL = 8'h00;
  localparam logic [7:0] MCADC_REG_CLK = 8'h04;
  localparam logic [7:0] MCADC_REG_TRIG = 8'h08;
  localparam logic [7:0] MCADC_REG_POST = 8'h0C;
  localparam logic [7:0] MCADC_REG_COUNT = 8'h10;
  localparam logic [7:0] MCADC_REG_BASE = 8'h14;
  localparam logic [7:0] MCADC_REG_SIZE = 8'h18;
  localparam logic [7:0] MCADC_REG_STATUS = 8'h1C;
  localparam logic [7:0] MCADC_REG_XFER = 8'h20;
  localparam logic [7:0] MCADC_REG_START_IDX = 8'h24;

  localparam int MCADC_CTRL_START_BIT = 0;
  localparam int MCADC_CTRL_STOP_BIT = 1;
  localparam int MCADC_CTRL_RES10_BIT = 2;
  localparam int MCADC_CTRL_CHCNT_LSB = 4;
  localparam int MCADC_CLK_SRC_LSB = 0;
  localparam int MCADC_CLK_FASTER_BIT = 2;
  localparam int MCADC_CLK_DIV_LSB = 16;
  localparam int MCADC_TRIG_MODE_LSB = 0;
  localparam int MCADC_TRIG_SRC_LSB = 4;
  localparam int MCADC_TRIG_SLOPE_BIT = 8;
  localparam int MCADC_TRIG_LEVEL_LSB = 16;
  localparam int MCADC_STAT_DIVERR_BIT = 2;
  localparam int MCADC_STAT_OVERRUN_BIT = 3;

  localparam logic [10:0] MCADC_DIV_RST = 11'h002;
  localparam logic [10:0] MCADC_DIV_MIN = 11'h002;
  localparam logic [10:0] MCADC_DIV_MAX = 11'h400;

  typedef enum logic [2:0] {
    MCADC_S_IDLE = 3'b000,
    MCADC_S_WAIT_TRIG = 3'b001,
    MCADC_S_DELAY = 3'b010,
    MCADC_S_RUN = 3'b011,
    MCADC_S_FLUSH = 3'b100
  } mcadc_state_t;

  localparam logic [2:0] MCADC_MODE_SOFTWARE = 3'h0;
  localparam logic [2:0] MCADC_MODE_POST = 3'h1;
  localparam logic [2:0] MCADC_MODE_PRE = 3'h2;
  localparam logic [2:0] MCADC_DELAYED_EVENT_MODE = 3'h3;
  localparam logic [2:0] MCADC_MODE_MIDDLE = 3'h4;

  localparam logic [2:0] MCADC_EVENT_SOURCE_CHANNEL0 = 3'h0;
  localparam logic [2:0] MCADC_EVENT_SOURCE_CHANNEL1 = 3'h1;
  localparam logic [2:0] MCADC_EVENT_SOURCE_CHANNEL2 = 3'h2;
  localparam logic [2:0] MCADC_EVENT_SOURCE_CHANNEL3 = 3'h3;
  localparam logic [2:0] MCADC_EVENT_SOURCE_EXTERNAL = 3'h4;

  localparam logic [1:0] MCADC_CLOCK_SOURCE_INTERNAL = 2'h0;
  localparam logic [1:0] MCADC_CLOCK_SOURCE_EXT_SINE = 2'h1;
  localparam logic [1:0] MCADC_CLOCK_SOURCE_EXT_SQUARE = 2'h2;

  localparam logic [1:0] MCADC_XFER_DONE = 2'h0;
  localparam logic [1:0] MCADC_XFER_ACTIVE = 2'h1;
  localparam logic [1:0] MCADC_XFER_WAIT_TRIG = 2'h2;
  localparam logic [1:0] MCADC_XFER_WAIT_DELAY = 2'h3;
endpackage
`default_nettype wire

/* test_multichannel_adc_capture_dma.sv */
// Self-checking bench for the capture sequencer and its host memory.
// Assumes the host model file is compiled first; external clocks toggled by hand.
`timescale 1ns/1ps
`default_nettype none
module test_multichannel_adc_capture_dma;
  import mcadc_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [11:0] c0 = 12'hABC, c1 = 12'h123, c2 = 12'h5A7, c3 = 12'hF0E;
  logic [2:0] di = 3'h5;
  logic ext_trig = 1'b0;
  logic ext_sine = 1'b0;
  logic ext_square = 1'b0;
  logic slow = 1'b0;
  logic [3:0] adc_ch_enable;
  logic adc_convert;
  logic [31:0] mst_addr, mst_wdata;
  logic mst_valid, mst_ready;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  int conv_cnt = 0;

  mcadc_capture i_dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .adc_ch0_data(c0), .adc_ch1_data(c1), .adc_ch2_data(c2), .adc_ch3_data(c3),
    .digital_in_0(di[0]), .digital_in_1(di[1]), .digital_in_2(di[2]),
    .ext_trig(ext_trig), .ext_sine_clk(ext_sine), .ext_square_clk(ext_square),
    .adc_ch_enable(adc_ch_enable), .adc_convert(adc_convert), .mst_addr(mst_addr),
    .mst_wdata(mst_wdata), .mst_valid(mst_valid), .mst_ready(mst_ready));
  mcadc_host_mem i_host (.sys_clk(sys_clk), .rst(rst), .slow(slow), .mst_addr(mst_addr),
    .mst_wdata(mst_wdata), .mst_valid(mst_valid), .mst_ready(mst_ready));

  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end

  // Guard against a hung handshake or a capture that never ends
  always @(posedge sys_clk)
  begin
    if (adc_convert === 1'b1)
      conv_cnt++;
    cyc++;
    if (cyc == 30000)
    begin
      error_cnt++;
      end_sim();
    end
  end

  function automatic logic [15:0] wd(input logic [11:0] c, input logic r10, input logic f);
    wd = r10 ? {c[11:2], 2'b00, f, di} : {c, f, di};
  endfunction

  task automatic end_sim();
    $display("Tests %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", n, e, g);
      error_cnt++;
    end
  endtask

  task automatic do_reset();
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    d = reg_rdata;
  endtask

  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(n, e, d);
  endtask

  task automatic wait_idle();
    logic [31:0] d;
    for (int i = 0; i < 400; i++)
    begin
      rd(MCADC_REG_STATUS, d);
      if (d[1:0] === MCADC_XFER_DONE)
        break;
    end
    chk("idle", 32'h0, {30'h0, d[1:0]});
  endtask

  task automatic t_regs();
    rchk("clk_rst", MCADC_REG_CLK, 32'h00020000);
    rchk("unmapped", 8'h30, 32'h0);
    wr(MCADC_REG_CLK, 32'h00030006);
    rchk("div_odd", MCADC_REG_STATUS, 32'h4);
    rchk("clk_kept", MCADC_REG_CLK, 32'h00020006);
    wr(MCADC_REG_CLK, 32'h04020000);
    rchk("div_big", MCADC_REG_STATUS, 32'h4);
    wr(MCADC_REG_CLK, 32'h04000000);
    rchk("div_max", MCADC_REG_CLK, 32'h04000000);
    wr(MCADC_REG_CLK, 32'h00080000);
    rchk("div_ok", MCADC_REG_CLK, 32'h00080000);
    wr(MCADC_REG_CTRL, 32'h1);
    rchk("no_chan", MCADC_REG_STATUS, 32'h0);
    $display("Test regs done");
  endtask

  task automatic t_two();
    wr(MCADC_REG_TRIG, 32'h0);
    wr(MCADC_REG_BASE, 32'h0);
    wr(MCADC_REG_SIZE, 32'h10);
    wr(MCADC_REG_COUNT, 32'h4);
    wr(MCADC_REG_CTRL, 32'h21);
    rchk("run", MCADC_REG_STATUS, 32'h1);
    chk("en2", 32'h3, {28'h0, adc_ch_enable});
    wait_idle();
    rchk("xfer2", MCADC_REG_XFER, 32'h4);
    chk("m0", {wd(c1, 0, 0), wd(c0, 0, 0)}, i_host.mem[0]);
    chk("m1", {wd(c1, 0, 0), wd(c0, 0, 0)}, i_host.mem[1]);
    $display("Test two done");
  endtask

  task automatic t_wrap();
    do_reset();
    slow <= 1'b1;
    wr(MCADC_REG_CLK, 32'h00100000);
    wr(MCADC_REG_SIZE, 32'h6);
    wr(MCADC_REG_COUNT, 32'h8);
    wr(MCADC_REG_CTRL, 32'h45);
    wait_idle();
    rchk("xfer4", MCADC_REG_XFER, 32'h8);
    rchk("start_idx", MCADC_REG_START_IDX, 32'h2);
    chk("w0", {wd(c3, 1, 0), wd(c2, 1, 0)}, i_host.mem[0]);
    chk("w1", {wd(c3, 1, 0), wd(c2, 1, 0)}, i_host.mem[1]);
    chk("w2", {wd(c1, 1, 0), wd(c0, 1, 0)}, i_host.mem[2]);
    chk("w3", 32'hA5A5A5A5, i_host.mem[3]);
    slow <= 1'b0;
    $display("Test wrap done");
  endtask

  // Fire raises channel one above level 0x20 and flips the external line
  task automatic t_trig(input logic [31:0] trig, input logic lv0, input logic [31:0] st0,
                        input logic [31:0] st1, input logic f);
    do_reset();
    ext_trig <= lv0;
    wr(MCADC_REG_CLK, 32'h00080000);
    wr(MCADC_REG_TRIG, trig);
    wr(MCADC_REG_POST, 32'h3);
    rchk("post", MCADC_REG_POST, 32'h3);
    wr(MCADC_REG_BASE, 32'h20);
    wr(MCADC_REG_COUNT, 32'h2);
    wr(MCADC_REG_CTRL, 32'h11);
    repeat (40) @(posedge sys_clk);
    rchk("wait_trig", MCADC_REG_STATUS, st0);
    ext_trig <= ~lv0;
    c1 <= 12'h7F0;
    repeat (12) @(posedge sys_clk);
    rchk("after_trig", MCADC_REG_STATUS, st1);
    wait_idle();
    chk("flag", {wd(c0, 0, f), wd(c0, 0, f)}, i_host.mem[8]);
    ext_trig <= 1'b0;
    c1 <= 12'h123;
    $display("Test trigger done");
  endtask

  task automatic t_stop();
    logic [31:0] d;
    wr(MCADC_REG_TRIG, 32'h0);
    wr(MCADC_REG_COUNT, 32'h3E8);
    wr(MCADC_REG_CTRL, 32'h11);
    repeat (50) @(posedge sys_clk);
    rchk("busy", MCADC_REG_STATUS, 32'h1);
    wr(MCADC_REG_CTRL, 32'h2);
    wait_idle();
    rd(MCADC_REG_XFER, d);
    chk("stopped", 32'h1, {31'h0, d > 32'h0 && d < 32'h3E8});
    $display("Test stop done");
  endtask

  // Square source, divisor 2: sine edges must be ignored, four square edges give two ticks
  task automatic t_extclk();
    int conv_base;
    conv_base = conv_cnt;
    wr(MCADC_REG_CLK, 32'h00020002);
    wr(MCADC_REG_COUNT, 32'h2);
    wr(MCADC_REG_CTRL, 32'h11);
    repeat (8)
    begin
      ext_sine <= ~ext_sine;
      repeat (3) @(posedge sys_clk);
    end
    rchk("sine_ignored", MCADC_REG_XFER, 32'h0);
    repeat (8)
    begin
      ext_square <= ~ext_square;
      repeat (3) @(posedge sys_clk);
    end
    wait_idle();
    rchk("square_xfer", MCADC_REG_XFER, 32'h2);
    chk("convert", conv_base + 2, conv_cnt);
    $display("Test clock source done");
  endtask

  initial
  begin
    do_reset();
    t_regs();
    t_two();
    t_wrap();
    t_trig(32'h41, 1'b0, 32'h2, 32'h1, 1'b1);
    t_trig(32'h00200013, 1'b0, 32'h2, 32'h3, 1'b1);
    t_trig(32'h142, 1'b1, 32'h1, 32'h0, 1'b0);
    t_trig(32'h44, 1'b0, 32'h1, 32'h1, 1'b0);
    t_stop();
    t_extclk();
    end_sim();
  end
endmodule
`default_nettype wire
